// >>> design/lpmc_low_power_mode_control.v
// Low-power mode controller: stop, wait and halt sequencing over AHB-Lite
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`include "lpmc_defines.vh"

// ==========================================================================
module lpmc_low_power_mode_control #(
   parameter STOP_IS_HALT  = 1'b1,
   parameter LONG_STAB     = 1'b0,
   parameter WDOG_ENABLE   = 1'b1
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        ext_irq_n,
   input  wire        ext_reset_n,
   input  wire        low_voltage_reset,
   input  wire        timer_irq,
   input  wire        timer1_irq,
   input  wire        watchdog_timeout,
   output reg         cpu_clk_en,
   output reg         osc_en,
   output reg         timer_clk_en,
   output reg         watchdog_run,
   output reg         cpu_irq,
   output reg         sys_reset,
   output reg         stab_done
);

   // ======================================================================
   // State and registers
   localparam [11:0] STAB_N = LONG_STAB ? `LPMC_STAB_LONG : `LPMC_STAB_SHORT;

   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [11:0] stab_cnt_r;
   reg         imask_r;
   reg         xien_r;
   reg         xflag_r;
   reg  [7:0]  tmr_r;
   reg         rst_wake_r;
   reg         ph_wr_r;
   reg  [11:0] ph_addr_r;
   reg         xirq_s1_r;
   reg         xirq_s2_r;
   reg         xirq_d_r;
   reg         xrst_s1_r;
   reg         xrst_s2_r;
   reg         lvr_s1_r;
   reg         lvr_s2_r;
   reg         wd_s1_r;
   reg         wd_s2_r;
   reg         ti_s1_r;
   reg         ti_s2_r;

   wire        acc_ok;
   wire        wr_ctrl;
   wire        wr_tmr;
   wire        any_rst;
   wire        wd_rst;
   wire        xirq_edge;
   wire        tmr_wake;
   wire        stab_hit;
   wire        stop_hit;
   wire        wait_hit;

   // Helper: word select on an address, latched for writes, live for reads
   function is_reg;
      input [11:0] a;
      input [11:0] ofs;
      begin
         is_reg = (a[11:2] == ofs[11:2]);
      end
   endfunction

   // ======================================================================
   // Input synchronisers; all outside sources pass two flip-flops
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xirq_s1_r <= 1'b0;
         xirq_s2_r <= 1'b0;
         xirq_d_r  <= 1'b0;
         xrst_s1_r <= 1'b0;
         xrst_s2_r <= 1'b0;
         lvr_s1_r  <= 1'b0;
         lvr_s2_r  <= 1'b0;
         wd_s1_r   <= 1'b0;
         wd_s2_r   <= 1'b0;
         ti_s1_r   <= 1'b0;
         ti_s2_r   <= 1'b0;
      end else begin
         xirq_s1_r <= ~ext_irq_n;
         xirq_s2_r <= xirq_s1_r;
         xirq_d_r  <= xirq_s2_r;
         xrst_s1_r <= ~ext_reset_n;
         xrst_s2_r <= xrst_s1_r;
         lvr_s1_r  <= low_voltage_reset;
         lvr_s2_r  <= lvr_s1_r;
         wd_s1_r   <= watchdog_timeout;
         wd_s2_r   <= wd_s1_r;
         ti_s1_r   <= timer_irq | timer1_irq;
         ti_s2_r   <= ti_s1_r;
      end
   end

   // Falling edge of the external line is the interrupt event
   assign xirq_edge = xirq_s2_r & ~xirq_d_r;
   assign any_rst   = xrst_s2_r | lvr_s2_r;
   // watchdog expiry is a reset too, except while frozen in stop
   assign wd_rst    = WDOG_ENABLE[0] & wd_s2_r &
                      (state_r != `LPMC_ST_STOP);
   // timer wake from wait needs the interrupt mask clear
   assign tmr_wake  = ti_s2_r & ~imask_r;

   // ======================================================================
   // AHB-Lite slave: zero wait states, always OKAY
   assign acc_ok  = hsel & hready & htrans[1];
   assign wr_ctrl = ph_wr_r & is_reg(ph_addr_r, `LPMC_OFS_CTRL);
   assign wr_tmr  = ph_wr_r & is_reg(ph_addr_r, `LPMC_OFS_TIMER);
   assign stop_hit = wr_ctrl & hwdata[`LPMC_CTRL_STOP] &
                     (state_r == `LPMC_ST_RUN);
   assign wait_hit = wr_ctrl & hwdata[`LPMC_CTRL_WAIT] &
                     ~hwdata[`LPMC_CTRL_STOP] & (state_r == `LPMC_ST_RUN);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_r   <= 1'b0;
         ph_addr_r <= 12'h000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         ph_wr_r   <= acc_ok & hwrite;
         if (acc_ok) begin
            ph_addr_r <= haddr;
         end
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Read data registered at the address phase; unmapped reads give zero
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (acc_ok & ~hwrite) begin
         if (is_reg(haddr, `LPMC_OFS_CTRL))
            hrdata <= {28'h0000000, xien_r, imask_r, 2'b00};
         else if (is_reg(haddr, `LPMC_OFS_STATUS))
            hrdata <= {16'h0000, 1'b0, state_r, stab_cnt_r};
         else if (is_reg(haddr, `LPMC_OFS_TIMER))
            hrdata <= {24'h000000, tmr_r};
         else if (is_reg(haddr, `LPMC_OFS_OPTION))
            hrdata <= {24'h000000, 2'b00, xflag_r, rst_wake_r, 1'b0,
                       WDOG_ENABLE[0], LONG_STAB[0], STOP_IS_HALT[0]};
         else
            hrdata <= 32'h0000_0000;
      end
   end

   // ======================================================================
   // Mode sequencer
   assign stab_hit = (stab_cnt_r == STAB_N - 12'd1);

   always @* begin
      state_nxt = state_r;
      case (state_r)
         `LPMC_ST_RUN: begin
            // option picks true stop or halt
            if (stop_hit)
               state_nxt = STOP_IS_HALT ? `LPMC_ST_HALT : `LPMC_ST_STOP;
            else if (wait_hit)
               state_nxt = `LPMC_ST_WAIT;
         end
         `LPMC_ST_WAIT: begin
            // wait wake sources, watchdog reset included
            if (any_rst | wd_rst | xirq_edge | tmr_wake)
               state_nxt = `LPMC_ST_RUN;
         end
         `LPMC_ST_HALT: begin
            if (any_rst | wd_rst | xirq_edge | ti_s2_r)
               state_nxt = `LPMC_ST_RECOVER;
         end
         `LPMC_ST_STOP: begin
            // only external interrupt or resets wake stop
            if (any_rst | xirq_edge)
               state_nxt = `LPMC_ST_RECOVER;
         end
         `LPMC_ST_RECOVER: begin
            // leave when the stabilisation counter wraps
            if (stab_hit)
               state_nxt = `LPMC_ST_RUN;
         end
         default: state_nxt = `LPMC_ST_RUN;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r    <= `LPMC_ST_RUN;
         stab_cnt_r <= 12'h000;
         rst_wake_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         // counter held clear all through stop, free-running otherwise, wrapping at STAB_N - 1
         if ((state_r == `LPMC_ST_STOP) | stab_hit)
            stab_cnt_r <= 12'h000;
         else
            stab_cnt_r <= stab_cnt_r + 12'd1;
         if (state_r != `LPMC_ST_RUN && state_nxt != state_r)
            rst_wake_r <= any_rst | wd_rst;
      end
   end

   // ======================================================================
   // Interrupt mask, external enable and flag, timer control bits
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         imask_r <= `LPMC_CTRL_RST;
         xien_r  <= `LPMC_XIEN_RST;
         xflag_r <= 1'b0;
         tmr_r   <= `LPMC_TMR_RST;
      end else begin
         if (wr_ctrl) begin
            imask_r <= hwdata[`LPMC_CTRL_IMASK];
            xien_r  <= hwdata[`LPMC_CTRL_XIEN];
         end
         // stop or wait unmasks and arms external interrupt
         if (stop_hit | wait_hit) begin
            imask_r <= 1'b0;
            xien_r  <= 1'b1;
         end
         // Flag set beats software clear in the same cycle
         if (xirq_edge)
            xflag_r <= 1'b1;
         else if (wr_ctrl & hwdata[`LPMC_CTRL_XIEN] == 1'b0)
            xflag_r <= 1'b0;
         else if (cpu_irq)
            xflag_r <= 1'b0;
         if (wr_tmr)
            tmr_r <= hwdata[7:0];
         // true stop entry clears flags and enables; upper bits kept
         if (stop_hit & ~STOP_IS_HALT[0]) begin
            tmr_r[`LPMC_TMR_OVF_FLAG] <= 1'b0;
            tmr_r[`LPMC_TMR_PER_FLAG] <= 1'b0;
            tmr_r[`LPMC_TMR_OVF_EN]   <= 1'b0;
            tmr_r[`LPMC_TMR_PER_EN]   <= 1'b0;
         end
      end
   end

   // ======================================================================
   // Clock gates, watchdog run, reset and interrupt outputs
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_clk_en   <= 1'b1;
         osc_en       <= 1'b1;
         timer_clk_en <= 1'b1;
         watchdog_run <= 1'b0;
         cpu_irq      <= 1'b0;
         sys_reset    <= 1'b0;
         stab_done    <= 1'b0;
      end else begin
         // processor clock held in every low-power state
         cpu_clk_en   <= (state_nxt == `LPMC_ST_RUN);
         osc_en       <= (state_nxt != `LPMC_ST_STOP);
         timer_clk_en <= (state_nxt != `LPMC_ST_STOP);
         // watchdog frozen only by true stop
         watchdog_run <= WDOG_ENABLE[0] & (state_nxt != `LPMC_ST_STOP);
         // watchdog expiry resets in any running state
         sys_reset    <= any_rst | wd_rst;
         // external flag requests when enabled and unmasked
         cpu_irq      <= xflag_r & xien_r & ~imask_r & ~any_rst;
         stab_done    <= (state_r == `LPMC_ST_RECOVER) & stab_hit;
      end
   end

endmodule // lpmc_low_power_mode_control

// >>> design/lpmc_defines.vh
// Constants for the low-power mode controller
`ifndef LPMC_DEFINES_VH
`define LPMC_DEFINES_VH
// ==========================================================================
// Register byte offsets
`define LPMC_OFS_CTRL      12'h000
`define LPMC_OFS_STATUS    12'h004
`define LPMC_OFS_TIMER     12'h008
`define LPMC_OFS_OPTION    12'h00c
// ==========================================================================
// Control register fields (stop and wait act on a written 1; mask and enable are stored)
`define LPMC_CTRL_STOP     0
`define LPMC_CTRL_WAIT     1
`define LPMC_CTRL_IMASK    2
`define LPMC_CTRL_XIEN     3
// Timer register fields
`define LPMC_TMR_OVF_FLAG  0
`define LPMC_TMR_PER_FLAG  1
`define LPMC_TMR_OVF_EN    2
`define LPMC_TMR_PER_EN    3
`define LPMC_TMR_OTHER_LSB 4
`define LPMC_TMR_OTHER_MSB 7
// Reset values
`define LPMC_CTRL_RST      1'b1
`define LPMC_XIEN_RST      1'b1
`define LPMC_TMR_RST       8'h00
// ==========================================================================
// Stabilisation counts in processor clock cycles
`define LPMC_STAB_SHORT    12'd224
`define LPMC_STAB_LONG     12'd4064
// Mode encodings
`define LPMC_ST_RUN        3'd0
`define LPMC_ST_WAIT       3'd1
`define LPMC_ST_HALT       3'd2
`define LPMC_ST_STOP       3'd3
`define LPMC_ST_RECOVER    3'd4
`endif

// >>> dv/lpmc_far_side.sv
// Far-side model: one timer request and a watchdog counter
module lpmc_far_side #(
   parameter int WD_LIM = 40
) (
   input  wire logic hclk,
   input  wire logic timer_clk_en,
   input  wire logic watchdog_run,
   input  wire logic tmr_go,
   input  wire logic wd_arm,
   output logic      timer_irq,
   output logic      watchdog_timeout
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] tmr_r = 8'h00;
   logic [7:0] wd_r  = 8'h00;
   // ==========
   // timer counts only on its clock
   always @(posedge hclk) begin
      if (!tmr_go)
         tmr_r <= 8'h00;
      else if (timer_clk_en && tmr_r < 8'h10)
         tmr_r <= tmr_r + 8'h01;
   end
   assign timer_irq = tmr_go && tmr_r == 8'h10;
   always @(posedge hclk) begin
      if (!wd_arm)
         wd_r <= 8'h00;
      else if (watchdog_run && wd_r < WD_LIM)
         wd_r <= wd_r + 8'h01;
   end
   assign watchdog_timeout = wd_arm && wd_r >= WD_LIM;
endmodule // lpmc_far_side

// >>> dv/lpmc_props.sv
// Port checker for the low-power mode controller
module lpmc_props #(
   parameter LONG_STAB = 1'b0
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic ext_irq_n,
   input wire logic ext_reset_n,
   input wire logic low_voltage_reset,
   input wire logic watchdog_timeout,
   input wire logic cpu_clk_en,
   input wire logic osc_en,
   input wire logic timer_clk_en,
   input wire logic watchdog_run,
   input wire logic sys_reset,
   input wire logic stab_done
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STAB = LONG_STAB ? 4064 : 224;
   localparam int WAKE_MAX = 250;
   logic [12:0] cnt_r;
   logic        stop_r;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ==========
   // Cycles from oscillator restart to processor clock, after a stop only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r  <= 13'h0000;
         stop_r <= 1'b0;
      end else if (!osc_en) begin
         cnt_r  <= 13'h0000;
         stop_r <= 1'b1;
      end else if (cpu_clk_en) begin
         stop_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_r + 13'h0001;
      end
   end
   // ==========
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not zero-wait okay");
   a_stop_freeze: assert property (!osc_en |-> !cpu_clk_en && !watchdog_run)
      else $error("clock or watchdog alive in stop");
   a_stop_hold: assert property ((!osc_en && ext_irq_n && ext_reset_n
      && !low_voltage_reset)[*5] |=> !osc_en)
      else $error("stop left without a wake source");
   a_stab_count: assert property ($rose(cpu_clk_en) && stop_r |->
      cnt_r >= STAB - 1 && cnt_r <= STAB + 2)
      else $error("stabilisation count wrong");
   a_stab_pulse: assert property (stab_done |=> !stab_done)
      else $error("stab_done longer than one cycle");
   a_ext_reset: assert property (!ext_reset_n[*4] |-> sys_reset)
      else $error("external reset not passed on");
   a_lv_reset: assert property (low_voltage_reset[*4] |-> sys_reset)
      else $error("low-voltage reset not passed on");
   a_wdog_reset: assert property ((watchdog_timeout && osc_en)[*4] |-> sys_reset)
      else $error("watchdog expiry ignored");
   a_irq_wake: assert property ($fell(ext_irq_n) |-> ##[0:WAKE_MAX] cpu_clk_en)
      else $error("external request did not wake");
   a_timer_clk: assert property (osc_en |-> timer_clk_en)
      else $error("timer clock stopped with oscillator on");
   a_wdog_runs: assert property ((osc_en && !sys_reset)[*3] |-> watchdog_run)
      else $error("watchdog idle with oscillator on");
   c_stop: cover property ($fell(osc_en));
   c_wait: cover property ($fell(cpu_clk_en) && osc_en);
   c_wdog: cover property ($rose(sys_reset) && watchdog_timeout);
endmodule // lpmc_props

// >>> dv/test_low_power_mode_control.sv
// Self-checking bench for the low-power mode controller
`include "lpmc_defines.vh"
module test_low_power_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata;
   logic        hreadyout, hresp, cpu_clk_en, osc_en, timer_clk_en;
   logic        watchdog_run, cpu_irq, sys_reset, stab_done, timer_irq;
   logic        watchdog_timeout, ext_irq_n = 1'b1, ext_reset_n = 1'b1;
   logic        low_voltage_reset = 1'b0, tmr_go = 1'b0, wd_arm = 1'b0;
   logic        hsel = 1'b0, tmr1_irq = 1'b0;
   logic [5:0]  obs;
   int          miscompares = 0, checks_done = 0;
   assign obs = {cpu_irq, timer_irq, hreadyout, sys_reset, osc_en,
                 cpu_clk_en};
   lpmc_low_power_mode_control #(
      .STOP_IS_HALT (1'b0),
      .LONG_STAB    (1'b0),
      .WDOG_ENABLE  (1'b1)
   ) lpmc_low_power_mode_control_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .ext_irq_n(ext_irq_n), .ext_reset_n(ext_reset_n),
      .low_voltage_reset(low_voltage_reset), .timer_irq(timer_irq),
      .timer1_irq(tmr1_irq), .watchdog_timeout(watchdog_timeout),
      .cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
      .timer_clk_en(timer_clk_en), .watchdog_run(watchdog_run),
      .cpu_irq(cpu_irq), .sys_reset(sys_reset), .stab_done(stab_done)
   );
   lpmc_far_side #(.WD_LIM(40)) lpmc_far_side_inst (
      .hclk(hclk), .timer_clk_en(timer_clk_en),
      .watchdog_run(watchdog_run), .tmr_go(tmr_go), .wd_arm(wd_arm),
      .timer_irq(timer_irq), .watchdog_timeout(watchdog_timeout)
   );
   initial forever #12.5 hclk = ~hclk;
   // ==========
   task automatic give_verdict;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait on one observed output; a hang ends the run
   task automatic wait_for(input int k, input logic v, input int lim,
                           output int n);
      n = 0;
      while (obs[k] !== v && n < lim) begin
         @(posedge hclk);
         n++;
      end
      if (n >= lim) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, obs[k], v);
         give_verdict();
      end
   endtask
   // Single word transfer, address phase then data phase
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= a;
      @(posedge hclk);
      wait_for(3, 1'b1, 20, n);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      wait_for(3, 1'b1, 20, n);
      q = hrdata;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask
   // ==========
   task automatic t_regs;
      logic [31:0] q;
      rd(`LPMC_OFS_CTRL, 32'h0000000c);
      rd(12'h010, 32'h0); // unmapped place reads zero
      bus(1'b0, `LPMC_OFS_OPTION, 32'h0, q);
      chk(q & 32'h7, 32'h4);
   endtask
   task automatic t_wait;
      logic [31:0] q;
      int n;
      bus(1'b1, `LPMC_OFS_CTRL, 32'h4, q);
      bus(1'b1, `LPMC_OFS_CTRL, 32'h2, q);
      wait_for(0, 1'b0, 8, n);
      tmr_go <= 1'b1;
      wait_for(0, 1'b1, 60, n);
      tmr_go <= 1'b0;
      rd(`LPMC_OFS_CTRL, 32'h8);
      // Second timer source must wake wait as well
      bus(1'b1, `LPMC_OFS_CTRL, 32'h2, q);
      wait_for(0, 1'b0, 8, n);
      tmr1_irq <= 1'b1;
      wait_for(0, 1'b1, 20, n);
      tmr1_irq <= 1'b0;
   endtask
   // Timer request stays raised through stop until ext_irq_n falls; it must not wake
   task automatic t_stop;
      logic [31:0] q;
      int n;
      tmr_go <= 1'b1;
      bus(1'b1, `LPMC_OFS_TIMER, 32'hfc, q);
      wait_for(4, 1'b1, 30, n);
      bus(1'b1, `LPMC_OFS_CTRL, 32'h1, q);
      wait_for(1, 1'b0, 8, n);
      repeat (40) @(posedge hclk);
      chk({31'h0, osc_en}, 32'h0);
      tmr_go <= 1'b0;
      ext_irq_n <= 1'b0;
      wait_for(1, 1'b1, 20, n);
      wait_for(5, 1'b1, 4, n);
      wait_for(0, 1'b1, 300, n);
      chk({31'h0, n > 218 && n < 230}, 32'h1);
      ext_irq_n <= 1'b1;
      rd(`LPMC_OFS_TIMER, 32'hf0);
      rd(`LPMC_OFS_CTRL, 32'h8);
   endtask
   task automatic t_wdog;
      logic [31:0] q;
      int n;
      wd_arm <= 1'b1;
      bus(1'b1, `LPMC_OFS_CTRL, 32'h2, q);
      wait_for(2, 1'b1, 100, n);
      // watchdog armed only around wait, never into true stop
      wd_arm <= 1'b0;
      wait_for(2, 1'b0, 20, n);
      wait_for(0, 1'b1, 300, n);
      rd(`LPMC_OFS_OPTION, 32'h14);
   endtask
   task automatic t_resets;
      int n;
      for (int i = 0; i < 2; i++) begin
         // pass 0 pulls external reset low, pass 1 raises low-voltage reset
         ext_reset_n       <= (i != 0);
         low_voltage_reset <= (i != 0);
         wait_for(2, 1'b1, 10, n);
         ext_reset_n       <= 1'b1;
         low_voltage_reset <= 1'b0;
         wait_for(2, 1'b0, 10, n);
      end
   endtask
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_wait();
      t_stop();
      t_wdog();
      t_resets();
      give_verdict();
   end
endmodule // test_low_power_mode_control
bind lpmc_low_power_mode_control lpmc_props #(.LONG_STAB(LONG_STAB)) lpmc_props_inst (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .ext_irq_n(ext_irq_n), .ext_reset_n(ext_reset_n),
   .low_voltage_reset(low_voltage_reset),
   .watchdog_timeout(watchdog_timeout), .cpu_clk_en(cpu_clk_en),
   .osc_en(osc_en), .timer_clk_en(timer_clk_en),
   .watchdog_run(watchdog_run), .sys_reset(sys_reset), .stab_done(stab_done)
);
